/* hdl/adcc_control.sv */
/*
 * Control logic of a sigma-delta converter: burnout switching, reference
 * detect, serial-clock software reset, supply monitor selection and the
 * calibration and conversion sequencer with coefficient scaling.
 * Assumes mode and configuration inputs come from register logic on mclk_i,
 * raw_i is the modulator result on mclk_i, and din_i is valid at rising
 * sclk_i edges. cs_n_i and ref_bad_i are asynchronous pins.
 */
// Summary of operation
// - Burnout source and sink switch together
// - Burnout currents only on selected input pair
// - Reference check only when enabled
// - Bad reference sets missing reference flag
// - Missing reference forces conversion result ones
// - Missing reference blocks coefficient, sets error
// - Thirty-two ones on input reset all
// - Power-up performs the same reset
// - Supply setting converts supply over six
// - Mode field starts four calibration kinds
// - Subtract offset then multiply by full-scale
// - Completion updates coefficient, ready, pin, idle
// - Internal sources connected; system needs host voltage
// - Offset calibrations take two conversion cycles
// - Internal full-scale: two cycles gain one, else four
// - Pin high at start, low at completion
// - Full-scale coefficient stored per selected channel
// - Gain 128: no internal full-scale, factory load, system allowed
// - System full-scale takes two conversion cycles
// - Continuous mode clears ready low per conversion
`timescale 1ns/100ps
`include "adcc_map.svh"

module adcc_control #(
	parameter int RESET_WAIT_CYCLES = `ADCC_RESET_WAIT_US * `ADCC_MCLK_MHZ
) (
	input  wire logic                      mclk_i,
	input  wire logic                      arst_n_i,
	input  wire logic                      sclk_i,
	input  wire logic                      din_i,
	input  wire logic                      cs_n_i,
	input  wire logic                      ref_bad_i,
	input  wire adcc_pkg::adcc_cfg_type    cfg_i,
	input  wire logic                      mode_write_i,
	input  wire logic [2:0]                operating_mode_field_i,
	input  wire logic                      data_read_i,
	input  wire logic [23:0]               raw_i,
	output logic                           dout_rdy_o,
	output logic                           dout_rdy_oe_o,
	output adcc_pkg::adcc_status_type      status_o,
	output logic [2:0]                     mode_o,
	output logic [23:0]                    data_o,
	output logic [23:0]                    offset_coef_o,
	output logic [23:0]                    fs_coef_o,
	output adcc_pkg::adcc_burnout_type     burnout_o,
	output logic                           supply_monitor_o,
	output logic                           int_ref_sel_o,
	output logic                           cal_zero_src_o,
	output logic                           cal_full_src_o,
	output logic                           mod_reset_o,
	output logic                           reset_busy_o
);

	////////////////////////////////////////////////////////////////////////
	// Functions

	function automatic logic [1:0] chan_idx(input logic [2:0] sel);
		chan_idx = (sel < 3'h3) ? sel[1:0] : 2'h0;
	endfunction

	function automatic logic [23:0] scale(input logic [23:0] raw,
	                                      input logic [23:0] off,
	                                      input logic [23:0] fs);
		logic [23:0] diff;
		logic [47:0] prod;
		diff = raw - off + `ADCC_MID_CODE;
		prod = diff * fs;
		scale = prod[47] ? `ADCC_ALL_ONES : prod[46:23];
	endfunction

	function automatic logic is_cal(input logic [2:0] md);
		is_cal = md[2];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Serial clock domain: run of ones on the data input

	logic [5:0] ones_cnt_reg;
	logic       rst_tgl_reg;

	always_ff @(posedge sclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ones_cnt_reg <= 6'h00;
			rst_tgl_reg  <= 1'b0;
		end else if (!din_i) begin
			ones_cnt_reg <= 6'h00;
		end else if (ones_cnt_reg == `ADCC_ONES_LAST) begin
			ones_cnt_reg <= 6'h00;
			rst_tgl_reg  <= ~rst_tgl_reg;
		end else begin
			ones_cnt_reg <= ones_cnt_reg + 6'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Synchronisers

	logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
	logic cs_s1_reg, cs_s2_reg;
	logic ref_s1_reg, ref_s2_reg;
	logic sw_rst;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tgl_s1_reg <= 1'b0;
			tgl_s2_reg <= 1'b0;
			tgl_s3_reg <= 1'b0;
			cs_s1_reg  <= 1'b1;
			cs_s2_reg  <= 1'b1;
			ref_s1_reg <= 1'b0;
			ref_s2_reg <= 1'b0;
		end else begin
			tgl_s1_reg <= rst_tgl_reg;
			tgl_s2_reg <= tgl_s1_reg;
			tgl_s3_reg <= tgl_s2_reg;
			cs_s1_reg  <= cs_n_i;
			cs_s2_reg  <= cs_s1_reg;
			ref_s1_reg <= ref_bad_i;
			ref_s2_reg <= ref_s1_reg;
		end
	end

	assign sw_rst = tgl_s2_reg ^ tgl_s3_reg;

	////////////////////////////////////////////////////////////////////////
	// Reset pulse to modulator and filter, settle window

	logic        mod_reset_reg;
	logic        busy_reg;
	logic [31:0] wait_cnt_reg;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mod_reset_reg <= 1'b1;
			busy_reg      <= 1'b1;
			wait_cnt_reg  <= 32'h0000_0000;
		end else if (sw_rst) begin
			mod_reset_reg <= 1'b1;
			busy_reg      <= 1'b1;
			wait_cnt_reg  <= 32'h0000_0000;
		end else begin
			mod_reset_reg <= 1'b0;
			if (busy_reg) begin
				if (wait_cnt_reg == 32'(RESET_WAIT_CYCLES - 1))
					busy_reg <= 1'b0;
				wait_cnt_reg <= wait_cnt_reg + 32'h0000_0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reference detect

	logic missing_reference_flag_reg;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			missing_reference_flag_reg <= 1'b0;
		else if (sw_rst)
			missing_reference_flag_reg <= 1'b0;
		else
			missing_reference_flag_reg <= cfg_i.reference_check_enable & ref_s2_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	adcc_pkg::adcc_state_type state_reg;
	logic [2:0]  mode_reg;
	logic [15:0] conv_cnt_reg;
	logic [2:0]  cal_cnt_reg;
	logic [2:0]  cal_len_reg;
	logic        cal_err_reg;
	logic        err_reg;
	logic        rdy_n_reg;
	logic [23:0] data_reg;
	logic [23:0] offset_reg [0:2];
	logic [23:0] fs_reg [0:2];
	logic [2:0]  gain_prev_reg;
	logic [1:0]  idx;
	logic        tick;
	logic        cal_done;
	logic        skip_cal;

	assign idx  = chan_idx(cfg_i.input_select_field);
	assign tick = (state_reg != adcc_pkg::ST_IDLE) &&
	              (conv_cnt_reg == `ADCC_CONV_CYCLES - 16'h0001);
	assign cal_done = (state_reg == adcc_pkg::ST_CAL) && tick &&
	                  (cal_cnt_reg + 3'h1 == cal_len_reg);
	assign skip_cal = mode_write_i &&
	                  operating_mode_field_i == `ADCC_MODE_INT_FULL &&
	                  cfg_i.gain == `ADCC_GAIN_128;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= adcc_pkg::ST_CONV;
			mode_reg  <= `ADCC_MODE_RST;
		end else if (sw_rst) begin
			state_reg <= adcc_pkg::ST_CONV;
			mode_reg  <= `ADCC_MODE_RST;
		end else if (mode_write_i) begin
			mode_reg <= operating_mode_field_i;
			case (operating_mode_field_i)
				`ADCC_MODE_CONT, `ADCC_MODE_SINGLE: begin
					state_reg <= adcc_pkg::ST_CONV;
				end
				`ADCC_MODE_IDLE, `ADCC_MODE_PDOWN: begin
					state_reg <= adcc_pkg::ST_IDLE;
				end
				default: begin
					if (skip_cal) begin
						state_reg <= adcc_pkg::ST_IDLE;
						mode_reg  <= `ADCC_MODE_IDLE;
					end else begin
						state_reg <= adcc_pkg::ST_CAL;
					end
				end
			endcase
		end else begin
			case (state_reg)
				adcc_pkg::ST_CONV: begin
					if (tick && mode_reg == `ADCC_MODE_SINGLE) begin
						state_reg <= adcc_pkg::ST_IDLE;
						mode_reg  <= `ADCC_MODE_IDLE;
					end
				end
				adcc_pkg::ST_CAL: begin
					if (cal_done) begin
						state_reg <= adcc_pkg::ST_IDLE;
						mode_reg  <= `ADCC_MODE_IDLE;
					end
				end
				adcc_pkg::ST_IDLE: begin
					state_reg <= adcc_pkg::ST_IDLE;
				end
				default: begin
					state_reg <= adcc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Conversion timer, restarted by every mode write
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			conv_cnt_reg <= 16'h0000;
		else if (sw_rst || mode_write_i || tick)
			conv_cnt_reg <= 16'h0000;
		else if (state_reg != adcc_pkg::ST_IDLE)
			conv_cnt_reg <= conv_cnt_reg + 16'h0001;
	end

	// Calibration length and reference watch
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cal_cnt_reg <= 3'h0;
			cal_len_reg <= `ADCC_CAL_SHORT;
			cal_err_reg <= 1'b0;
		end else if (sw_rst) begin
			cal_cnt_reg <= 3'h0;
			cal_len_reg <= `ADCC_CAL_SHORT;
			cal_err_reg <= 1'b0;
		end else if (mode_write_i) begin
			cal_cnt_reg <= 3'h0;
			cal_err_reg <= 1'b0;
			if (operating_mode_field_i == `ADCC_MODE_INT_FULL &&
			    cfg_i.gain != `ADCC_GAIN_1)
				cal_len_reg <= `ADCC_CAL_LONG;
			else
				cal_len_reg <= `ADCC_CAL_SHORT;
		end else if (state_reg == adcc_pkg::ST_CAL) begin
			if (missing_reference_flag_reg)
				cal_err_reg <= 1'b1;
			if (tick)
				cal_cnt_reg <= cal_cnt_reg + 3'h1;
		end
	end

	// Error flag: cleared when a calibration starts, set if one was spoiled
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			err_reg <= 1'b0;
		else if (sw_rst)
			err_reg <= 1'b0;
		else if (cal_done && (cal_err_reg || missing_reference_flag_reg))
			err_reg <= 1'b1;
		else if (mode_write_i && is_cal(operating_mode_field_i))
			err_reg <= 1'b0;
	end

	// Ready flag, active low
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			rdy_n_reg <= 1'b1;
		else if (sw_rst)
			rdy_n_reg <= 1'b1;
		else if (cal_done || skip_cal)
			rdy_n_reg <= 1'b0;
		else if (tick && state_reg == adcc_pkg::ST_CONV)
			rdy_n_reg <= 1'b0;
		else if (mode_write_i && is_cal(operating_mode_field_i))
			rdy_n_reg <= 1'b1;
		else if (data_read_i)
			rdy_n_reg <= 1'b1;
	end

	// Data register
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			data_reg <= 24'h00_0000;
		else if (sw_rst)
			data_reg <= 24'h00_0000;
		else if (tick && state_reg == adcc_pkg::ST_CONV)
			data_reg <= missing_reference_flag_reg ? `ADCC_ALL_ONES
			          : scale(raw_i, offset_reg[idx], fs_reg[idx]);
	end

	// Coefficients per channel
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < 3; i++) begin
				offset_reg[i] <= `ADCC_OFFSET_RST;
				fs_reg[i]     <= `ADCC_FS_RST;
			end
			gain_prev_reg <= `ADCC_GAIN_1;
		end else if (sw_rst) begin
			for (int i = 0; i < 3; i++) begin
				offset_reg[i] <= `ADCC_OFFSET_RST;
				fs_reg[i]     <= `ADCC_FS_RST;
			end
			gain_prev_reg <= cfg_i.gain;
		end else begin
			gain_prev_reg <= cfg_i.gain;
			if (cal_done && !cal_err_reg && !missing_reference_flag_reg) begin
				if (mode_reg == `ADCC_MODE_INT_ZERO ||
				    mode_reg == `ADCC_MODE_SYS_ZERO)
					offset_reg[idx] <= raw_i;
				else
					fs_reg[idx] <= raw_i;
			end else if (cfg_i.gain == `ADCC_GAIN_128 &&
			             gain_prev_reg != `ADCC_GAIN_128) begin
				fs_reg[idx] <= `ADCC_FS_FACTORY;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs

	logic                       pin_reg;
	logic                       pin_oe_reg;
	adcc_pkg::adcc_burnout_type bo_reg;
	logic                       supply_reg;
	logic                       zsrc_reg;
	logic                       fsrc_reg;
	logic [23:0]                off_out_reg;
	logic [23:0]                fs_out_reg;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_reg    <= 1'b1;
			pin_oe_reg <= 1'b0;
		end else begin
			pin_reg    <= cs_s2_reg | rdy_n_reg;
			pin_oe_reg <= ~cs_s2_reg;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bo_reg     <= '0;
			supply_reg <= 1'b0;
		end else begin
			bo_reg.source <= cfg_i.burnout_enable_bit &&
			                 cfg_i.input_select_field < 3'h3 ?
			                 3'h1 << idx : 3'h0;
			bo_reg.sink   <= cfg_i.burnout_enable_bit &&
			                 cfg_i.input_select_field < 3'h3 ?
			                 3'h1 << idx : 3'h0;
			supply_reg    <= cfg_i.input_select_field ==
			                 `ADCC_CH_SUPPLY;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			zsrc_reg    <= 1'b0;
			fsrc_reg    <= 1'b0;
			off_out_reg <= `ADCC_OFFSET_RST;
			fs_out_reg  <= `ADCC_FS_RST;
		end else begin
			zsrc_reg    <= state_reg == adcc_pkg::ST_CAL &&
			               mode_reg == `ADCC_MODE_INT_ZERO;
			fsrc_reg    <= state_reg == adcc_pkg::ST_CAL &&
			               mode_reg == `ADCC_MODE_INT_FULL;
			off_out_reg <= offset_reg[idx];
			fs_out_reg  <= fs_reg[idx];
		end
	end

	assign dout_rdy_o       = pin_reg;
	assign dout_rdy_oe_o    = pin_oe_reg;
	assign status_o.rdy_n   = rdy_n_reg;
	assign status_o.missing_reference_flag = missing_reference_flag_reg;
	assign status_o.err     = err_reg;
	assign mode_o           = mode_reg;
	assign data_o           = data_reg;
	assign offset_coef_o    = off_out_reg;
	assign fs_coef_o        = fs_out_reg;
	assign burnout_o        = bo_reg;
	assign supply_monitor_o = supply_reg;
	assign int_ref_sel_o    = supply_reg;
	assign cal_zero_src_o   = zsrc_reg;
	assign cal_full_src_o   = fsrc_reg;
	assign mod_reset_o      = mod_reset_reg;
	assign reset_busy_o     = busy_reg;

endmodule // adcc_control

/* hdl/adcc_map.svh */
/*
 * Constants of the converter control block: mode and channel codes,
 * coefficient reset values and timing counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// Operating mode field codes
`define ADCC_MODE_CONT       3'h0
`define ADCC_MODE_SINGLE     3'h1
`define ADCC_MODE_IDLE       3'h2
`define ADCC_MODE_PDOWN      3'h3
`define ADCC_MODE_INT_ZERO   3'h4
`define ADCC_MODE_INT_FULL   3'h5
`define ADCC_MODE_SYS_ZERO   3'h6
`define ADCC_MODE_SYS_FULL   3'h7
`define ADCC_MODE_RST        3'h0

// Input select and gain codes
`define ADCC_CH_SUPPLY       3'h7
`define ADCC_GAIN_1          3'h0
`define ADCC_GAIN_128        3'h7

// Coefficient values (full-scale coefficient 24'h80_0000 means unity)
`define ADCC_OFFSET_RST      24'h80_0000
`define ADCC_FS_RST          24'h80_0000
`define ADCC_FS_FACTORY      24'h80_0000
`define ADCC_MID_CODE        24'h80_0000
`define ADCC_ALL_ONES        24'hFF_FFFF

// Timing counts
`define ADCC_CONV_CYCLES     16'h03E8
`define ADCC_CAL_SHORT       3'h2
`define ADCC_CAL_LONG        3'h4
`define ADCC_ONES_LAST       6'h1F
`define ADCC_RESET_WAIT_US   500
`define ADCC_MCLK_MHZ        125

`endif

/* hdl/adcc_pkg.sv */
/*
 * Types of the converter control block.
 * Assumes the constants header is included before use of the block.
 */
package adcc_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CONV = 3'b010,
		ST_CAL  = 3'b100
	} adcc_state_type;

	typedef struct packed {
		logic       burnout_enable_bit;
		logic       reference_check_enable;
		logic [2:0] gain;
		logic [2:0] input_select_field;
	} adcc_cfg_type;

	typedef struct packed {
		logic rdy_n;
		logic missing_reference_flag;
		logic err;
	} adcc_status_type;

	typedef struct packed {
		logic [2:0] source;
		logic [2:0] sink;
	} adcc_burnout_type;

endpackage

/* tb/adcc_host_model.sv */
/*
 * Host side of the serial link: makes the serial clock inside frames only.
 * Assumes the testbench calls frame() while the core is otherwise idle.
 */
`timescale 1ns/100ps

module adcc_host_model (
	output logic sclk_o,
	output logic din_o
);
	initial begin
		sclk_o = 1'b1;
		din_o  = 1'b0;
	end

	////////////////////////////////////////
	// Clock idles high between frames, 32 ns period within them
	task automatic frame(input int ones, input bit tail);
		for (int i = 0; i < ones + tail; i++) begin
			#16 sclk_o = 1'b0;
			din_o = (i < ones);
			#16 sclk_o = 1'b1;
		end
		#16 din_o = ~din_o;
	endtask
endmodule // adcc_host_model

/* tb/adcc_control_monitor.sv */
/*
 * Concurrent checks on the converter control ports.
 * Assumes binding into adcc_control and the shared constants header.
 */
`timescale 1ns/100ps
`include "adcc_map.svh"

module adcc_control_monitor #(
	parameter int RESET_WAIT_CYCLES = 20
) (
	input wire logic                  mclk_i,
	input wire logic                  arst_n_i,
	input wire logic                  cs_n_i,
	input wire logic                  ref_bad_i,
	input wire adcc_pkg::adcc_cfg_type cfg_i,
	input wire logic                  mode_write_i,
	input wire logic [2:0]            operating_mode_field_i,
	input wire logic                  dout_rdy_o,
	input wire adcc_pkg::adcc_status_type status_o,
	input wire logic [2:0]            mode_o,
	input wire logic [23:0]           data_o,
	input wire logic [23:0]           offset_coef_o,
	input wire logic [23:0]           fs_coef_o,
	input wire adcc_pkg::adcc_burnout_type burnout_o,
	input wire logic                  supply_monitor_o,
	input wire logic                  int_ref_sel_o,
	input wire logic                  mod_reset_o,
	input wire logic                  reset_busy_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	logic [15:0] cal_cnt_reg;
	logic        cal_long_reg;
	logic        ref_seen_reg;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			cal_cnt_reg <= 16'h0000;
		else
			cal_cnt_reg <= mode_o[2] ? cal_cnt_reg + 16'h0001 : 16'h0000;
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			cal_long_reg <= 1'b0;
		else if (mode_write_i)
			cal_long_reg <= operating_mode_field_i == `ADCC_MODE_INT_FULL
				&& cfg_i.gain != `ADCC_GAIN_1;
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			ref_seen_reg <= 1'b0;
		else
			ref_seen_reg <= mode_o[2]
				&& (ref_seen_reg || status_o.missing_reference_flag);
	end

	////////////////////////////////////////
	sequence s_cal_start;
		mode_write_i && operating_mode_field_i[2] && !mod_reset_o
			&& !(operating_mode_field_i == `ADCC_MODE_INT_FULL
			&& cfg_i.gain == `ADCC_GAIN_128);
	endsequence

	sequence s_cal_end;
		$fell(mode_o[2]) && mode_o == `ADCC_MODE_IDLE && cal_cnt_reg > 16;
	endsequence

	a_burnout_pair_match: assert property (
		burnout_o.source == burnout_o.sink)
		else $error("burnout source and sink differ");
	a_burnout_on_channel: assert property ($past(arst_n_i) |->
		burnout_o.source == (($past(cfg_i.burnout_enable_bit)
		&& $past(cfg_i.input_select_field) < 3'h3)
		? 3'h1 << $past(cfg_i.input_select_field) : 3'h0))
		else $error("burnout not on selected pair");
	a_refcheck_gated: assert property (
		$rose(status_o.missing_reference_flag)
		|-> $past(cfg_i.reference_check_enable))
		else $error("missing reference flag while check off");
	a_badref_flagged: assert property (
		(ref_bad_i && cfg_i.reference_check_enable) [*4]
		|-> ##[0:3] status_o.missing_reference_flag)
		else $error("bad reference not flagged");
	a_missing_reference_flag_all_ones: assert property (
		$changed(data_o) && $past(status_o.missing_reference_flag)
		&& !reset_busy_o |-> data_o == `ADCC_ALL_ONES)
		else $error("result not all ones without reference");
	a_missing_reference_flag_cal_error: assert property (
		s_cal_end ##0 ref_seen_reg |-> ##[0:1] status_o.err
		##1 $stable(offset_coef_o) && $stable(fs_coef_o))
		else $error("calibration without reference not blocked");
	a_soft_reset_values: assert property (
		$rose(mod_reset_o) |-> ##[0:3] (mode_o == `ADCC_MODE_RST
		&& data_o == 24'h00_0000 && offset_coef_o == `ADCC_OFFSET_RST))
		else $error("soft reset did not restore defaults");
	a_supply_select: assert property ($past(arst_n_i) |->
		supply_monitor_o == ($past(cfg_i.input_select_field)
		== `ADCC_CH_SUPPLY) && int_ref_sel_o == supply_monitor_o)
		else $error("supply monitor select wrong");
	a_cal_start_pin: assert property (
		s_cal_start |=> status_o.rdy_n ##1 dout_rdy_o)
		else $error("calibration start not signalled");
	a_cal_done_ready: assert property (
		s_cal_end ##0 !ref_seen_reg |-> !status_o.rdy_n
		##1 (cs_n_i || !dout_rdy_o))
		else $error("calibration end not signalled");
	a_cal_length: assert property (
		s_cal_end |-> (cal_long_reg ? cal_cnt_reg inside {[3990:4010]}
		: cal_cnt_reg inside {[1990:2010]}))
		else $error("calibration length wrong");
	a_gain128_refused: assert property (
		mode_write_i && operating_mode_field_i == `ADCC_MODE_INT_FULL
		&& cfg_i.gain == `ADCC_GAIN_128 |=> mode_o == `ADCC_MODE_IDLE
		&& !status_o.rdy_n ##1 $stable(fs_coef_o))
		else $error("gain 128 internal full-scale not refused");
	a_gain128_factory: assert property (
		cfg_i.gain == `ADCC_GAIN_128 && $past(cfg_i.gain) != `ADCC_GAIN_128
		&& !mode_o[2] |-> ##[1:3] fs_coef_o == `ADCC_FS_FACTORY)
		else $error("factory full-scale not loaded");
endmodule // adcc_control_monitor

bind adcc_control adcc_control_monitor #(
	.RESET_WAIT_CYCLES(RESET_WAIT_CYCLES)
) u_adcc_control_monitor (.*);

/* tb/tb_top.sv */
/*
 * Self-checking bench of the converter control block.
 * Assumes the design, package, header, host model and monitor compile first.
 */
`timescale 1ns/100ps
`include "adcc_map.svh"

module tb_top;
	localparam int BUSY = 20;
	logic mclk_i, arst_n_i, cs_n_i, ref_bad_i, mode_write_i, data_read_i;
	logic dout_rdy_o, dout_rdy_oe_o, supply_monitor_o, int_ref_sel_o;
	logic mod_reset_o, reset_busy_o, sclk, din, zsrc, fsrc;
	logic rst_seen = 1'b0;
	logic [2:0] op_mode, mode_o;
	logic [23:0] raw_i, data_o, offset_coef_o, fs_coef_o;
	adcc_pkg::adcc_cfg_type cfg_i;
	adcc_pkg::adcc_status_type status_o;
	adcc_pkg::adcc_burnout_type burnout_o;
	int num_errors = 0;
	int tests_run = 0;

	always #4 mclk_i = ~mclk_i;
	// Soft reset pulses only: the power-up pulse rises while reset is low
	always @(posedge mod_reset_o) if (arst_n_i === 1'b1) rst_seen <= 1'b1;

	adcc_host_model u_adcc_host_model (.sclk_o(sclk), .din_o(din));
	adcc_control #(.RESET_WAIT_CYCLES(BUSY)) u_adcc_control (
		.mclk_i(mclk_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .din_i(din),
		.cs_n_i(cs_n_i), .ref_bad_i(ref_bad_i), .cfg_i(cfg_i),
		.mode_write_i(mode_write_i), .operating_mode_field_i(op_mode),
		.data_read_i(data_read_i), .raw_i(raw_i), .dout_rdy_o(dout_rdy_o),
		.dout_rdy_oe_o(dout_rdy_oe_o), .status_o(status_o), .mode_o(mode_o),
		.data_o(data_o), .offset_coef_o(offset_coef_o),
		.fs_coef_o(fs_coef_o), .burnout_o(burnout_o),
		.supply_monitor_o(supply_monitor_o), .int_ref_sel_o(int_ref_sel_o),
		.mod_reset_o(mod_reset_o), .reset_busy_o(reset_busy_o),
		.cal_zero_src_o(zsrc), .cal_full_src_o(fsrc));

	////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	task automatic wr_mode(input logic [2:0] m);
		@(posedge mclk_i);
		op_mode <= m;
		mode_write_i <= 1'b1;
		@(posedge mclk_i);
		mode_write_i <= 1'b0;
	endtask

	task automatic wait_rdy(output int c);
		c = 0;
		while (status_o.rdy_n !== 1'b0 && c < 5000) begin
			@(posedge mclk_i);
			c++;
		end
	endtask

	task automatic wait_busy;
		for (int c = 0; c < 100 && reset_busy_o !== 1'b0; c++) tick(1);
	endtask

	task automatic cal(input logic [2:0] m, input logic [23:0] r, int n);
		int c;
		raw_i <= r;
		wr_mode(m);
		tick(2);
		chk("pin_busy", 1, dout_rdy_o);
		chk("zero_src", m == `ADCC_MODE_INT_ZERO, zsrc);
		chk("full_src", m == `ADCC_MODE_INT_FULL, fsrc);
		wait_rdy(c);
		chk("cal_len", n, (c + 502) / 1000);
		tick(2);
		chk("pin_done", 0, dout_rdy_o);
		chk("mode_idle", `ADCC_MODE_IDLE, mode_o);
	endtask

	task automatic conv(input logic [23:0] r, e);
		int c;
		raw_i <= r;
		wr_mode(`ADCC_MODE_CONT);
		data_read_i <= 1'b1;
		tick(1);
		data_read_i <= 1'b0;
		tick(2);
		chk("rdy_read", 1, status_o.rdy_n);
		wait_rdy(c);
		tick(2);
		chk("data", e, data_o);
		chk("pin_conv", 0, dout_rdy_o);
	endtask

	function automatic logic [23:0] scale(input logic [23:0] r, o, f);
		logic [23:0] d;
		logic [47:0] p;
		d = r - o + 24'h80_0000;
		p = d * f;
		return p[47] ? 24'hFF_FFFF : p[46:23];
	endfunction

	task automatic final_report;
		$display("mismatches %0d comparisons %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	////////////////////////////////////////
	initial begin
		#400_000;
		num_errors++;
		final_report();
	end

	initial begin
		logic [2:0] b;
		mclk_i = 0; arst_n_i = 0; cs_n_i = 0; ref_bad_i = 0; cfg_i = '0;
		mode_write_i = 0; op_mode = 0; data_read_i = 0; raw_i = 0;
		tick(10);
		arst_n_i <= 1'b1;
		chk("busy", 1, reset_busy_o);
		wait_busy();
		chk("mode_rst", `ADCC_MODE_RST, mode_o);
		chk("fs_rst", `ADCC_FS_RST, fs_coef_o);
		chk("oe", 1, dout_rdy_oe_o);
		for (int ch = 0; ch < 8; ch++) begin
			cfg_i <= '{1'b1, 1'b0, 3'h0, ch[2:0]};
			tick(3);
			b = (ch < 3) ? 3'h1 << ch : 3'h0;
			chk("burnout", {b, b}, burnout_o);
			chk("supply", ch == 7, supply_monitor_o);
			chk("int_ref", ch == 7, int_ref_sel_o);
		end
		cfg_i <= '0;
		cs_n_i <= 1'b1;
		tick(4);
		chk("burnout_off", 0, burnout_o);
		chk("oe_off", 0, dout_rdy_oe_o);
		cs_n_i <= 1'b0;
		cal(`ADCC_MODE_INT_ZERO, 24'h00_0100, 2);
		chk("off_int", 24'h00_0100, offset_coef_o);
		cal(`ADCC_MODE_SYS_ZERO, 24'h00_0200, 2);
		chk("off_sys", 24'h00_0200, offset_coef_o);
		cal(`ADCC_MODE_INT_FULL, 24'h60_0000, 2);
		chk("fs_int1", 24'h60_0000, fs_coef_o);
		cfg_i.gain <= 3'h1;
		cal(`ADCC_MODE_INT_FULL, 24'h50_0000, 4);
		cfg_i.input_select_field <= 3'h1;
		tick(4);
		chk("fs_ch1", `ADCC_FS_RST, fs_coef_o);
		cfg_i.input_select_field <= 3'h0;
		tick(4);
		chk("fs_ch0", 24'h50_0000, fs_coef_o);
		cfg_i.gain <= `ADCC_GAIN_128;
		tick(4);
		chk("fs_factory", `ADCC_FS_FACTORY, fs_coef_o);
		wr_mode(`ADCC_MODE_INT_FULL);
		tick(3);
		chk("refused", `ADCC_MODE_IDLE, mode_o);
		chk("fs_kept", `ADCC_FS_FACTORY, fs_coef_o);
		cal(`ADCC_MODE_SYS_FULL, 24'h40_0000, 2);
		chk("fs_sys", 24'h40_0000, fs_coef_o);
		conv(24'h90_0200, scale(24'h90_0200, 24'h00_0200, 24'h40_0000));
		ref_bad_i <= 1'b1;
		tick(10);
		chk("missing_reference_flag_off", 0, status_o.missing_reference_flag);
		cfg_i.reference_check_enable <= 1'b1;
		tick(10);
		chk("missing_reference_flag_on", 1, status_o.missing_reference_flag);
		conv(24'h12_3456, `ADCC_ALL_ONES);
		cal(`ADCC_MODE_SYS_ZERO, 24'h00_0300, 2);
		chk("err", 1, status_o.err);
		chk("off_blocked", 24'h00_0200, offset_coef_o);
		ref_bad_i <= 1'b0;
		cfg_i.reference_check_enable <= 1'b0;
		u_adcc_host_model.frame(31, 1);
		tick(40);
		chk("no_reset", 0, rst_seen);
		u_adcc_host_model.frame(32, 0);
		tick(40);
		chk("soft_reset", 1, rst_seen);
		chk("off_dflt", `ADCC_OFFSET_RST, offset_coef_o);
		chk("err_dflt", 0, status_o.err);
		wait_busy();
		arst_n_i <= 1'b0;
		tick(3);
		arst_n_i <= 1'b1;
		wait_busy();
		chk("fs_again", `ADCC_FS_RST, fs_coef_o);
		final_report();
	end
endmodule // tb_top
